// >>> serial_memory_programming_port_tb.sv
`timescale 1ns/1ps
module serial_memory_programming_port_tb;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  // shortened waits keep the run short; the erase wait must exceed the 8192-cycle erase sweep
  localparam int unsigned WT = 9000;
  logic clock, sys_rst, reset_pin_n, sck, mosi, miso, miso_oe;
  logic prog_enabled, busy, run_normal;
  logic [31:0] rx;
  logic [7:0] d;
  logic [7:0] fl_m [int];
  logic [7:0] ee_m [int];
  logic [7:0] idv [4];
  int fails, checks_done, a, p, i;
  int q[$];

  initial clock = 1'b0;
  always #2 clock = ~clock;

  smpp_top #(.FLASH_WAIT_CYC(WT), .EE_WAIT_CYC(WT), .ERASE_WAIT_CYC(WT),
    .FUSE_WAIT_CYC(WT)) dut (.clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .prog_enabled(prog_enabled),
    .busy(busy), .run_normal(run_normal));
  // a released line reads as the inverse, so stale data cannot pass
  smpp_prog_model prog (.sck(sck), .mosi(mosi), .miso(miso_oe ? miso : ~miso));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] fc(logic [7:0] op, int ba, logic [7:0] dt);
    return {op[7:4], ba[0], op[2:0], 4'h0, ba[12:9], ba[8:1], dt};
  endfunction
  function automatic logic [31:0] ec(logic [7:0] op, int ea, logic [7:0] dt);
    return {op, 7'h00, ea[8], ea[7:0], dt};
  endfunction
  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 15000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 15000) begin
      check("busy end", 8'h01, 8'h00);
      finish_test();
    end
  endtask
  task automatic rd(string n, logic [31:0] c, logic [7:0] e);
    prog.xfer(c, rx);
    check(n, rx[7:0], e);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hc44c));
    idv = '{smpp_pkg::SIG_B0, smpp_pkg::SIG_B1, smpp_pkg::SIG_B2, smpp_pkg::CAL_BYTE};
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    fails = 0;
    checks_done = 0;
    cyc(6);
    sys_rst <= 1'b0;
    cyc(10);
    @(negedge clock);
    check("normal", {7'h00, run_normal}, 8'h01);
    cyc(1);
    reset_pin_n <= 1'b0;
    cyc(20);
    check("miso_oe", {7'h00, miso_oe}, 8'h01);
    prog.xfer({8'hAC, 8'h80, 16'h0000}, rx);
    cyc(8);
    @(negedge clock);
    check("early erase", {7'h00, busy}, 8'h00);
    prog.xfer({smpp_pkg::ENABLE_B1, smpp_pkg::ENABLE_B2, 16'h1234}, rx);
    check("echo", rx[15:8], smpp_pkg::ENABLE_B2);
    cyc(8);
    @(negedge clock);
    check("enabled", {7'h00, prog_enabled}, 8'h01);
    prog.xfer({8'hAC, 8'h80, 16'h0000}, rx);
    cyc(8);
    rd("erase poll", fc(8'h20, $urandom_range(8191), 8'h00), 8'hFF);
    wait_idle();
    rd("erased fl", fc(8'h20, $urandom_range(8191), 8'h00), 8'hFF);
    rd("erased ee", ec(8'hA0, $urandom_range(511), 8'h00), 8'hFF);
    // second write is the complement, so a missing auto-erase shows
    a = $urandom_range(511);
    d = $urandom_range(254, 1);
    for (i = 0; i < 2; i++) begin
      prog.xfer(ec(8'hC0, a, d), rx);
      cyc(8);
      rd("ee poll", ec(8'hA0, a, 8'h00), 8'hFF);
      wait_idle();
      ee_m[a] = d;
      rd("ee", ec(8'hA0, a, 8'h00), ee_m[a]);
      d = ~d;
    end
    p = $urandom_range(127);
    for (i = 0; i < 4; i++) begin
      a = p * 64 + $urandom_range(31) * 2;
      fl_m[a] = $urandom_range(254);
      prog.xfer(fc(8'h40, a, fl_m[a]), rx);
      fl_m[a + 1] = $urandom_range(254);
      prog.xfer(fc(8'h40, a + 1, fl_m[a + 1]), rx);
      q.push_back(a);
      q.push_back(a + 1);
    end
    prog.xfer(fc(8'h4C, p * 64 + 1, 8'h00), rx);
    cyc(8);
    rd("page poll", fc(8'h20, p * 64 + $urandom_range(63), 8'h00), 8'hFF);
    wait_idle();
    foreach (q[k]) rd("flash", fc(8'h20, q[k], 8'h00), fl_m[q[k]]);
    for (i = 0; i < 4; i++) begin
      rd("id", {i < 3 ? 8'h30 : 8'h38, 14'h0000, i < 3 ? i[1:0] : 2'h0, 8'h00}, idv[i]);
    end
    // fuse and lock writes cannot be polled, so the bench rides on busy
    d = $urandom_range(255);
    prog.xfer({8'hAC, 8'hA0, 8'h00, d}, rx);
    wait_idle();
    rd("fuse lo", {8'h50, 8'h00, 16'h0000}, d);
    rd("fuse hi", {8'h58, 8'h08, 16'h0000}, smpp_pkg::FUSE_HI_RESET);
    d[7:6] = 2'h3;
    prog.xfer({8'hAC, 8'hE0, 8'h00, d}, rx);
    wait_idle();
    rd("lock", {8'h58, 8'h00, 16'h0000}, d);
    cyc(1);
    reset_pin_n <= 1'b1;
    cyc(10);
    @(negedge clock);
    check("end normal", {7'h00, run_normal}, 8'h01);
    check("end enable", {7'h00, prog_enabled}, 8'h00);
    check("end oe", {7'h00, miso_oe}, 8'h00);
    cyc(1);
    reset_pin_n <= 1'b0;
    cyc(20);
    prog.xfer(ec(8'hC0, a, 8'h11), rx);
    cyc(8);
    @(negedge clock);
    check("relock", {7'h00, busy}, 8'h00);
    finish_test();
  end
endmodule

// >>> smpp_assertions.sv
`timescale 1ns/1ps
module smpp_assertions #(
  parameter int unsigned FLASH_WAIT_CYC = 1,
  parameter int unsigned EE_WAIT_CYC = 1,
  parameter int unsigned ERASE_WAIT_CYC = 1,
  parameter int unsigned FUSE_WAIT_CYC = 1
) (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // serial pins
  input wire logic reset_pin_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  // status
  input wire logic prog_enabled,
  input wire logic busy,
  input wire logic run_normal
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam int unsigned M1 = FLASH_WAIT_CYC < FUSE_WAIT_CYC ? FLASH_WAIT_CYC : FUSE_WAIT_CYC;
  localparam int unsigned M2 = EE_WAIT_CYC < ERASE_WAIT_CYC ? EE_WAIT_CYC : ERASE_WAIT_CYC;
  localparam int unsigned LO = M1 < M2 ? M1 : M2;
  localparam int unsigned X1 = FLASH_WAIT_CYC > FUSE_WAIT_CYC ? FLASH_WAIT_CYC : FUSE_WAIT_CYC;
  localparam int unsigned X2 = EE_WAIT_CYC > ERASE_WAIT_CYC ? EE_WAIT_CYC : ERASE_WAIT_CYC;
  // slack covers the 64-cycle page copy, which runs alongside the timed wait
  localparam int unsigned HI = (X1 > X2 ? X1 : X2) + 80;
  int unsigned busy_len_r;
  logic miso_rise_r;
  always_ff @(posedge clock) begin
    if (sys_rst || !busy) begin
      busy_len_r <= 0;
    end else begin
      busy_len_r <= busy_len_r + 1;
    end
  end
  // miso must hold through the high phase, so compare at the fall
  always_ff @(posedge sck) begin
    miso_rise_r <= miso;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_reset_clears: assert property (@(posedge clock)
    sys_rst |=> !miso_oe && !prog_enabled && !busy && !run_normal)
    else $error("outputs not cleared in reset");
  a_pin_high_normal: assert property (@(posedge clock) disable iff (sys_rst)
    reset_pin_n [*8] |-> run_normal && !miso_oe && !prog_enabled)
    else $error("pin high but not normal run");
  a_pin_low_session: assert property (@(posedge clock) disable iff (sys_rst)
    !reset_pin_n [*8] |-> miso_oe && !run_normal)
    else $error("pin low but no session");
  a_busy_after_enable: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(busy) |-> $past(prog_enabled) && miso_oe)
    else $error("write started without enable");
  a_busy_length: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(busy) |-> busy_len_r >= LO && busy_len_r <= HI)
    else $error("busy length out of range");
  a_enable_drops: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(reset_pin_n) |-> ##[1:8] !prog_enabled)
    else $error("enable kept after pin rise");
  a_enable_in_session: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(prog_enabled) |-> miso_oe && !run_normal && !busy)
    else $error("enable outside session");
  a_miso_holds_high: assert property (@(negedge sck) disable iff (sys_rst || !miso_oe)
    miso == miso_rise_r)
    else $error("miso moved while sck high");
endmodule

bind smpp_top smpp_assertions #(.FLASH_WAIT_CYC(FLASH_WAIT_CYC), .EE_WAIT_CYC(EE_WAIT_CYC),
  .ERASE_WAIT_CYC(ERASE_WAIT_CYC), .FUSE_WAIT_CYC(FUSE_WAIT_CYC)) u_chk (.clock(clock),
  .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .prog_enabled(prog_enabled), .busy(busy), .run_normal(run_normal));

// >>> smpp_mem.sv
`timescale 1ns/1ps
module smpp_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock
  input wire logic clock,
  // access port
  smpp_mem_if.mem port
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // single port, read data always registered
  always_ff @(posedge clock) begin
    if (port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
    rdata_r <= mem_r[port.addr];
  end

  assign port.rdata = rdata_r;

endmodule

// >>> smpp_mem_if.sv
`timescale 1ns/1ps
interface smpp_mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

// >>> smpp_pkg.sv
package smpp_pkg;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] ENABLE_B1 = 8'hAC;
  localparam logic [7:0] ENABLE_B2 = 8'h53;
  localparam logic [2:0] ERASE_B2_TOP = 3'h4;
  localparam logic [2:0] LOCK_B2_TOP = 3'h7;
  localparam logic [7:0] FUSE_LO_B2 = 8'hA0;
  localparam logic [7:0] FUSE_HI_B2 = 8'hA8;
  localparam logic [6:0] RD_FLASH_OP = 7'h10;
  localparam logic [6:0] LD_PAGE_OP = 7'h20;
  localparam logic [7:0] WR_PAGE_OP = 8'h4C;
  localparam logic [7:0] RD_EE_OP = 8'hA0;
  localparam logic [7:0] WR_EE_OP = 8'hC0;
  localparam logic [7:0] RD_LOCK_OP = 8'h58;
  localparam logic [7:0] RD_FUSE_OP = 8'h50;
  localparam logic [7:0] RD_SIG_OP = 8'h30;
  localparam logic [7:0] RD_CAL_OP = 8'h38;
  localparam logic [7:0] RD_LOCK_B2 = 8'h00;
  localparam logic [7:0] RD_FUSEH_B2 = 8'h08;

  // ----------------------------------------------------------------
  // memory geometry and values
  // ----------------------------------------------------------------
  localparam int FLASH_AW = 13;
  localparam int EE_AW = 9;
  localparam int BUF_AW = 6;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [12:0] PAGE_LAST = 13'h003F;
  localparam logic [12:0] ERASE_LAST = 13'h1FFF;
  localparam logic [5:0] LOCK_RESET = 6'h3F;
  localparam logic [1:0] LOCK_PAD = 2'h3;
  localparam logic [7:0] FUSE_LO_RESET = 8'hFF;
  localparam logic [7:0] FUSE_HI_RESET = 8'hFF;
  // identity bytes: arbitrary neutral values
  localparam logic [7:0] SIG_B0 = 8'h5A;
  localparam logic [7:0] SIG_B1 = 8'h01;
  localparam logic [7:0] SIG_B2 = 8'h02;
  localparam logic [7:0] CAL_BYTE = 8'h80;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned FLASH_WAIT_US = 4500;
  localparam int unsigned EE_WAIT_US = 9000;
  localparam int unsigned ERASE_WAIT_US = 9000;
  localparam int unsigned FUSE_WAIT_US = 4500;
  localparam int unsigned FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
  localparam int unsigned EE_WAIT_CYC = EE_WAIT_US * CLK_MHZ;
  localparam int unsigned ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  localparam int unsigned FUSE_WAIT_CYC = FUSE_WAIT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    BSY_IDLE, BSY_PAGE, BSY_EE, BSY_ERASE, BSY_FUSE
  } smpp_busy_t;

endpackage

// >>> smpp_prog_model.sv
`timescale 1ns/1ps
module smpp_prog_model (
  // serial pins toward the device
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // 10 cpu cycles a phase, above the roughly 8-cycle floor
  localparam realtime HALF = 40.0;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  // always sends whole four-byte frames, msb first; sck idles low
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rx);
    #3;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #HALF;
      sck = 1'b1;
      rx[i] = miso;
      #HALF;
      sck = 1'b0;
    end
    // line not meaningful between frames
    mosi = ~mosi;
  endtask
endmodule

// >>> smpp_spi_link.sv
`timescale 1ns/1ps
module smpp_spi_link (
  // link clock and clear
  input wire logic sck,
  input wire logic link_clr,
  // serial pins
  input wire logic mosi,
  output logic miso,
  // byte exchange with the cpu domain
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic rx_tgl
);

  logic [2:0] bit_cnt_r;
  logic [6:0] in_sh_r;
  logic [1:0] byte_idx_r;
  logic [7:0] out_sh_r;

  // clear is raised only while sck is held low, so its release is safe
  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_r <= 3'h0;
      in_sh_r <= 7'h00;
      byte_idx_r <= 2'h0;
      rx_byte <= 8'h00;
      rx_tgl <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      in_sh_r <= {in_sh_r[5:0], mosi};
      if (bit_cnt_r == 3'h7) begin
        rx_byte <= {in_sh_r, mosi};
        rx_tgl <= ~rx_tgl;
        byte_idx_r <= byte_idx_r + 2'h1;
      end
    end
  end

  // tx_byte is only read as the fourth byte starts, half an sck period after the third byte lands;
  // this needs each sck half period to exceed about eight cpu cycles
  always_ff @(negedge sck or posedge link_clr) begin
    if (link_clr) begin
      out_sh_r <= 8'h00;
      miso <= 1'b0;
    end else if (bit_cnt_r == 3'h0) begin
      if (byte_idx_r == 2'h3) begin
        out_sh_r <= tx_byte;
        miso <= tx_byte[7];
      end else begin
        out_sh_r <= rx_byte;
        miso <= rx_byte[7];
      end
    end else begin
      out_sh_r <= {out_sh_r[6:0], 1'b0};
      miso <= out_sh_r[6];
    end
  end

endmodule

// >>> smpp_top.sv
`timescale 1ns/1ps
module smpp_top #(
  parameter int unsigned FLASH_WAIT_CYC = smpp_pkg::FLASH_WAIT_CYC,
  parameter int unsigned EE_WAIT_CYC = smpp_pkg::EE_WAIT_CYC,
  parameter int unsigned ERASE_WAIT_CYC = smpp_pkg::ERASE_WAIT_CYC,
  parameter int unsigned FUSE_WAIT_CYC = smpp_pkg::FUSE_WAIT_CYC
) (
  // system
  input wire logic clock,
  input wire logic sys_rst,
  // serial programming pins
  input wire logic reset_pin_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // device status
  output logic prog_enabled,
  output logic busy,
  output logic run_normal
);

  // ----------------------------------------------------------------
  // reset pin and session
  // ----------------------------------------------------------------
  logic pin_s1_r;
  logic pin_s2_r;
  logic session_r;
  logic link_clr_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      session_r <= 1'b0;
      link_clr_r <= 1'b1;
      miso_oe <= 1'b0;
      run_normal <= 1'b0;
    end else begin
      session_r <= ~pin_s2_r;
      link_clr_r <= pin_s2_r;
      miso_oe <= ~pin_s2_r;
      run_normal <= pin_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // link and byte crossing
  // ----------------------------------------------------------------
  logic [7:0] tx_byte_r;
  logic [7:0] rx_byte;
  logic rx_tgl;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic byte_evt;

  smpp_spi_link u_link (
    .sck(sck),
    .link_clr(link_clr_r),
    .mosi(mosi),
    .miso(miso),
    .tx_byte(tx_byte_r),
    .rx_byte(rx_byte),
    .rx_tgl(rx_tgl)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= rx_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // rx_byte holds still for a whole byte time after its toggle
  assign byte_evt = session_r && (tgl_s2_r != tgl_s3_r);

  // ----------------------------------------------------------------
  // instruction assembly and decode
  // ----------------------------------------------------------------
  logic [1:0] byte_cnt_r;
  logic [7:0] b1_r;
  logic [7:0] b2_r;
  logic [7:0] b3_r;
  logic rd_req_r;
  logic rd_req2_r;
  logic exec;
  logic hbit;
  logic is_enable;
  logic is_erase;
  logic is_wr_lock;
  logic is_wr_fuse;
  logic is_wr_fuseh;
  logic is_rd_flash;
  logic is_ld_page;
  logic is_wr_page;
  logic is_rd_ee;
  logic is_wr_ee;

  always_ff @(posedge clock) begin
    if (sys_rst || !session_r) begin
      byte_cnt_r <= 2'h0;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
      rd_req_r <= 1'b0;
      rd_req2_r <= 1'b0;
    end else begin
      rd_req_r <= byte_evt && (byte_cnt_r == 2'h2);
      rd_req2_r <= rd_req_r;
      if (byte_evt) begin
        byte_cnt_r <= byte_cnt_r + 2'h1;
        case (byte_cnt_r)
          2'h0: b1_r <= rx_byte;
          2'h1: b2_r <= rx_byte;
          2'h2: b3_r <= rx_byte;
          default: ;
        endcase
      end
    end
  end

  assign exec = byte_evt && (byte_cnt_r == 2'h3);
  assign hbit = b1_r[3];
  assign is_enable = (b1_r == smpp_pkg::ENABLE_B1) && (b2_r == smpp_pkg::ENABLE_B2);
  assign is_erase = (b1_r == smpp_pkg::ENABLE_B1) && (b2_r[7:5] == smpp_pkg::ERASE_B2_TOP);
  assign is_wr_lock = (b1_r == smpp_pkg::ENABLE_B1) && (b2_r[7:5] == smpp_pkg::LOCK_B2_TOP);
  assign is_wr_fuse = (b1_r == smpp_pkg::ENABLE_B1) && (b2_r == smpp_pkg::FUSE_LO_B2);
  assign is_wr_fuseh = (b1_r == smpp_pkg::ENABLE_B1) && (b2_r == smpp_pkg::FUSE_HI_B2);
  assign is_rd_flash = ({b1_r[7:4], b1_r[2:0]} == smpp_pkg::RD_FLASH_OP);
  assign is_ld_page = ({b1_r[7:4], b1_r[2:0]} == smpp_pkg::LD_PAGE_OP);
  assign is_wr_page = (b1_r == smpp_pkg::WR_PAGE_OP);
  assign is_rd_ee = (b1_r == smpp_pkg::RD_EE_OP);
  assign is_wr_ee = (b1_r == smpp_pkg::WR_EE_OP);

  // ----------------------------------------------------------------
  // enable and acceptance
  // ----------------------------------------------------------------
  smpp_pkg::smpp_busy_t busy_kind_r;
  logic accept;

  always_ff @(posedge clock) begin
    if (sys_rst || !session_r) begin
      prog_enabled <= 1'b0;
    end else if (exec && is_enable) begin
      prog_enabled <= 1'b1;
    end
  end

  // writes during a running operation are dropped rather than risk damage
  assign accept = exec && prog_enabled && (busy_kind_r == smpp_pkg::BSY_IDLE);

  // ----------------------------------------------------------------
  // self-timed operations
  // ----------------------------------------------------------------
  logic [31:0] wait_r;
  logic [6:0] page_r;
  logic [8:0] ee_busy_addr_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_kind_r <= smpp_pkg::BSY_IDLE;
      wait_r <= 32'h0000_0000;
      busy <= 1'b0;
    end else begin
      case (busy_kind_r)
        smpp_pkg::BSY_IDLE: begin
          if (accept && is_wr_page) begin
            busy_kind_r <= smpp_pkg::BSY_PAGE;
            wait_r <= FLASH_WAIT_CYC;
            busy <= 1'b1;
          end else if (accept && is_wr_ee) begin
            busy_kind_r <= smpp_pkg::BSY_EE;
            wait_r <= EE_WAIT_CYC;
            busy <= 1'b1;
          end else if (accept && is_erase) begin
            busy_kind_r <= smpp_pkg::BSY_ERASE;
            wait_r <= ERASE_WAIT_CYC;
            busy <= 1'b1;
          end else if (accept && (is_wr_lock || is_wr_fuse || is_wr_fuseh)) begin
            busy_kind_r <= smpp_pkg::BSY_FUSE;
            wait_r <= FUSE_WAIT_CYC;
            busy <= 1'b1;
          end
        end
        default: begin
          if (wait_r == 32'h0000_0000) begin
            busy_kind_r <= smpp_pkg::BSY_IDLE;
            busy <= 1'b0;
          end else begin
            wait_r <= wait_r - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      page_r <= 7'h00;
      ee_busy_addr_r <= 9'h000;
    end else if (accept && is_wr_page) begin
      page_r <= {b2_r[3:0], b3_r[7:5]};
    end else if (accept && is_wr_ee) begin
      ee_busy_addr_r <= {b2_r[0], b3_r};
    end
  end

  // ----------------------------------------------------------------
  // sweep for page commit and chip erase
  // ----------------------------------------------------------------
  logic sweep_on_r;
  logic [12:0] sweep_cnt_r;
  logic swd_on_r;
  logic [5:0] swd_idx_r;
  logic page_sweep;
  logic erase_sweep;

  assign page_sweep = sweep_on_r && (busy_kind_r == smpp_pkg::BSY_PAGE);
  assign erase_sweep = sweep_on_r && (busy_kind_r == smpp_pkg::BSY_ERASE);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sweep_on_r <= 1'b0;
      sweep_cnt_r <= 13'h0000;
    end else if (accept && (is_wr_page || is_erase)) begin
      sweep_on_r <= 1'b1;
      sweep_cnt_r <= 13'h0000;
    end else if (sweep_on_r) begin
      sweep_cnt_r <= sweep_cnt_r + 13'h0001;
      if ((page_sweep && sweep_cnt_r == smpp_pkg::PAGE_LAST) ||
          (erase_sweep && sweep_cnt_r == smpp_pkg::ERASE_LAST)) begin
        sweep_on_r <= 1'b0;
      end
    end
  end

  // buffer read data lags one cycle, so the flash write trails the read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      swd_on_r <= 1'b0;
      swd_idx_r <= 6'h00;
    end else begin
      swd_on_r <= page_sweep;
      swd_idx_r <= sweep_cnt_r[5:0];
    end
  end

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  smpp_mem_if #(.AW(smpp_pkg::FLASH_AW), .DW(8)) flash_if ();
  smpp_mem_if #(.AW(smpp_pkg::EE_AW), .DW(8)) ee_if ();
  smpp_mem_if #(.AW(smpp_pkg::BUF_AW), .DW(8)) buf_if ();

  smpp_mem #(.AW(smpp_pkg::FLASH_AW), .DW(8)) u_flash (.clock(clock), .port(flash_if.mem));
  smpp_mem #(.AW(smpp_pkg::EE_AW), .DW(8)) u_eeprom (.clock(clock), .port(ee_if.mem));
  smpp_mem #(.AW(smpp_pkg::BUF_AW), .DW(8)) u_page_buf (.clock(clock), .port(buf_if.mem));

  always_comb begin
    if (erase_sweep) begin
      flash_if.addr = sweep_cnt_r;
      flash_if.we = 1'b1;
      flash_if.wdata = smpp_pkg::ERASED;
    end else if (swd_on_r) begin
      flash_if.addr = {page_r, swd_idx_r};
      flash_if.we = 1'b1;
      flash_if.wdata = buf_if.rdata;
    end else begin
      flash_if.addr = {b2_r[3:0], b3_r, hbit};
      flash_if.we = 1'b0;
      flash_if.wdata = smpp_pkg::ERASED;
    end
  end

  // an eeprom write simply replaces the byte: erase is folded in
  always_comb begin
    if (erase_sweep) begin
      ee_if.addr = sweep_cnt_r[8:0];
      ee_if.we = 1'b1;
      ee_if.wdata = smpp_pkg::ERASED;
    end else if (accept && is_wr_ee) begin
      ee_if.addr = {b2_r[0], b3_r};
      ee_if.we = 1'b1;
      ee_if.wdata = rx_byte;
    end else begin
      ee_if.addr = {b2_r[0], b3_r};
      ee_if.we = 1'b0;
      ee_if.wdata = smpp_pkg::ERASED;
    end
  end

  always_comb begin
    if (page_sweep) begin
      buf_if.addr = sweep_cnt_r[5:0];
      buf_if.we = 1'b0;
      buf_if.wdata = smpp_pkg::ERASED;
    end else begin
      buf_if.addr = {b3_r[4:0], hbit};
      buf_if.we = accept && is_ld_page;
      buf_if.wdata = rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // fuse and lock bits
  // ----------------------------------------------------------------
  logic [5:0] lock_r;
  logic [7:0] fuse_lo_r;
  logic [7:0] fuse_hi_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_r <= smpp_pkg::LOCK_RESET;
      fuse_lo_r <= smpp_pkg::FUSE_LO_RESET;
      fuse_hi_r <= smpp_pkg::FUSE_HI_RESET;
    end else if (accept && is_erase) begin
      lock_r <= smpp_pkg::LOCK_RESET;
    end else if (accept && is_wr_lock) begin
      lock_r <= rx_byte[5:0];
    end else if (accept && is_wr_fuse) begin
      fuse_lo_r <= rx_byte;
    end else if (accept && is_wr_fuseh) begin
      fuse_hi_r <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // read answer for the fourth byte
  // ----------------------------------------------------------------
  logic flash_hidden;
  logic ee_hidden;

  assign flash_hidden = (busy_kind_r == smpp_pkg::BSY_ERASE) ||
    ((busy_kind_r == smpp_pkg::BSY_PAGE) && ({b2_r[3:0], b3_r[7:5]} == page_r));
  assign ee_hidden = (busy_kind_r == smpp_pkg::BSY_ERASE) ||
    ((busy_kind_r == smpp_pkg::BSY_EE) && ({b2_r[0], b3_r} == ee_busy_addr_r));

  always_ff @(posedge clock) begin
    if (sys_rst || !session_r) begin
      tx_byte_r <= 8'h00;
    end else if (rd_req2_r) begin
      if (is_rd_flash) begin
        tx_byte_r <= flash_hidden ? smpp_pkg::ERASED : flash_if.rdata;
      end else if (is_rd_ee) begin
        tx_byte_r <= ee_hidden ? smpp_pkg::ERASED : ee_if.rdata;
      end else if (b1_r == smpp_pkg::RD_LOCK_OP && b2_r == smpp_pkg::RD_LOCK_B2) begin
        tx_byte_r <= {smpp_pkg::LOCK_PAD, lock_r};
      end else if (b1_r == smpp_pkg::RD_LOCK_OP && b2_r == smpp_pkg::RD_FUSEH_B2) begin
        tx_byte_r <= fuse_hi_r;
      end else if (b1_r == smpp_pkg::RD_FUSE_OP) begin
        tx_byte_r <= fuse_lo_r;
      end else if (b1_r == smpp_pkg::RD_SIG_OP) begin
        case (b3_r[1:0])
          2'h0: tx_byte_r <= smpp_pkg::SIG_B0;
          2'h1: tx_byte_r <= smpp_pkg::SIG_B1;
          2'h2: tx_byte_r <= smpp_pkg::SIG_B2;
          default: tx_byte_r <= 8'h00;
        endcase
      end else if (b1_r == smpp_pkg::RD_CAL_OP) begin
        tx_byte_r <= smpp_pkg::CAL_BYTE;
      end else begin
        tx_byte_r <= 8'h00;
      end
    end
  end

endmodule
